// >>> inc/cpgb_defines.svh
// constants for the configuration-port gpio bank
// assumes an 8-bit i/o port cycle interface with single-cycle strobes
// Function
// - two unlock writes to index enter configuration mode
// - one lock write leaves configuration mode
// - device 7 routes E0h to E2h to gpio
// - bit 7 at 30h, device 9, enables gpio
// - direction bit one is input, zero output
// - output line data bit writable and readable
// - input line data reads pin, ignores writes
// - polarity one inverts both directions
// - polarity zero passes value unchanged
`ifndef CPGB_DEFINES_SVH
`define CPGB_DEFINES_SVH
`define CPGB_IDX_PORT    16'h002e
`define CPGB_DAT_PORT    16'h002f
`define CPGB_UNLOCK_VAL  8'h87
`define CPGB_LOCK_VAL    8'haa
`define CPGB_IDX_LDN     8'h07
`define CPGB_IDX_EN      8'h30
`define CPGB_IDX_DIR     8'he0
`define CPGB_IDX_DATA    8'he1
`define CPGB_IDX_INV     8'he2
`define CPGB_LDN_GPIO    8'h07
`define CPGB_LDN_EN      8'h09
`define CPGB_EN_BIT      7
`define CPGB_RST_LDN     8'h00
`define CPGB_RST_EN      8'h00
`define CPGB_RST_DIR     8'hff
`define CPGB_RST_DATA    8'h00
`define CPGB_RST_INV     8'h00
`define CPGB_RST_IDX     8'h00
`define CPGB_LOCKED_RD   8'hff
`define CPGB_UNMAPPED_RD 8'h00
`endif

// >>> inc/cpgb_pkg.sv
// types for the configuration-port gpio bank
// assumes cpgb_defines.svh is included by users needing constants
package cpgb_pkg;
  typedef enum logic [1:0] {
    CPGB_LOCKED = 2'b00,
    CPGB_HALF   = 2'b01,
    CPGB_OPEN   = 2'b10
  } cpgb_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       idx_sel;
    logic       dat_sel;
    logic [7:0] wdata;
  } cpgb_io_req_t;
endpackage

// >>> core/cpgb_sync.sv
// three-stage input synchroniser with agreement filter
// assumes d_i is asynchronous to clk_i
`timescale 1ns/100ps
`default_nettype none
module cpgb_sync
  import cpgb_pkg::*;
#(
  parameter int W = 8
)
(
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] q_ff;
  logic [W-1:0] nxt_q;

  // a bit moves only once stages two and three agree
  always_comb
  begin
    nxt_q = (~(s2_ff ^ s3_ff) & s2_ff) | ((s2_ff ^ s3_ff) & q_ff);
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      q_ff  <= '0;
    end
    else if (ce_i)
    begin
      s1_ff <= d_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      q_ff  <= nxt_q;
    end
  end

  assign q_o = q_ff;
endmodule
`default_nettype wire

// >>> core/cpgb_top.sv
// gpio bank behind an index/data configuration port pair
// assumes one-cycle i/o read and write strobes on CORE_CLK_I
`timescale 1ns/100ps
`default_nettype none
`include "cpgb_defines.svh"
module cpgb_top
  import cpgb_pkg::*;
#(
  parameter int W = 8
)
(
  input  wire logic         CORE_CLK_I,
  input  wire logic         RESET_N_I,
  input  wire logic         CLK_EN_I,
  input  wire logic [15:0]  IO_ADDR_I,
  input  wire logic         IO_WR_I,
  input  wire logic         IO_RD_I,
  input  wire logic [7:0]   IO_WDATA_I,
  output logic      [7:0]   IO_RDATA_O,
  output logic              IO_RVALID_O,
  input  wire logic [W-1:0] GPIO_IN_I,
  output logic      [W-1:0] GPIO_OUT_O,
  output logic      [W-1:0] GPIO_OE_O
);
  function automatic logic cpgb_hit(input logic [7:0] idx,
                                    input logic [7:0] ldn,
                                    input logic [7:0] want_idx,
                                    input logic [7:0] want_ldn);
    cpgb_hit = (idx == want_idx) && (ldn == want_ldn);
  endfunction

  logic [1:0]   rst_sync_ff;
  logic         rst_n;
  cpgb_io_req_t req;
  logic         ce;
  cpgb_state_t  state_ff;
  cpgb_state_t  nxt_state;
  logic [7:0]   idx_ff;
  logic [7:0]   nxt_idx;
  logic [7:0]   ldn_ff;
  logic [7:0]   nxt_ldn;
  logic [7:0]   en_ff;
  logic [7:0]   nxt_en;
  logic [W-1:0] dir_ff;
  logic [W-1:0] nxt_dir;
  logic [W-1:0] dout_ff;
  logic [W-1:0] nxt_dout;
  logic [W-1:0] inv_ff;
  logic [W-1:0] nxt_inv;
  logic [7:0]   rdata_ff;
  logic [7:0]   nxt_rdata;
  logic         rvalid_ff;
  logic         nxt_rvalid;
  logic [W-1:0] out_ff;
  logic [W-1:0] nxt_out;
  logic [W-1:0] oe_ff;
  logic [W-1:0] nxt_oe;
  logic [W-1:0] pin_sync;
  logic [W-1:0] pin_val;
  logic [W-1:0] data_view;
  logic         open_wr;

  // reset released through two flops
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      rst_sync_ff <= 2'b00;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];
  assign ce    = CLK_EN_I;

  always_comb
  begin
    req.wr      = IO_WR_I;
    req.rd      = IO_RD_I;
    req.idx_sel = (IO_ADDR_I == `CPGB_IDX_PORT);
    req.dat_sel = (IO_ADDR_I == `CPGB_DAT_PORT);
    req.wdata   = IO_WDATA_I;
  end

  cpgb_sync #(
    .W (W)
  ) u_pin_sync (
    .clk_i   (CORE_CLK_I),
    .rst_n_i (rst_n),
    .ce_i    (ce),
    .d_i     (GPIO_IN_I),
    .q_o     (pin_sync)
  );

  assign pin_val   = pin_sync ^ inv_ff;
  assign data_view = (dout_ff & ~dir_ff) | (pin_val & dir_ff);
  assign open_wr   = req.wr && req.dat_sel && (state_ff == CPGB_OPEN);

  always_comb
  begin
    nxt_state  = state_ff;
    nxt_idx    = idx_ff;
    nxt_ldn    = ldn_ff;
    nxt_en     = en_ff;
    nxt_dir    = dir_ff;
    nxt_dout   = dout_ff;
    nxt_inv    = inv_ff;
    nxt_rdata  = rdata_ff;
    nxt_rvalid = 1'b0;
    // mode entry and exit on index port writes
    if (req.wr && req.idx_sel)
    begin
      case (state_ff)
        CPGB_LOCKED:
          if (req.wdata == `CPGB_UNLOCK_VAL)
            nxt_state = CPGB_HALF;
        CPGB_HALF:
          if (req.wdata == `CPGB_UNLOCK_VAL)
            nxt_state = CPGB_OPEN;
          else
            nxt_state = CPGB_LOCKED;
        CPGB_OPEN:
          if (req.wdata == `CPGB_LOCK_VAL)
            nxt_state = CPGB_LOCKED;
          else
            nxt_idx = req.wdata;
        default:
          nxt_state = CPGB_LOCKED;
      endcase
    end
    else if (req.wr && req.dat_sel && state_ff == CPGB_HALF)
      nxt_state = CPGB_LOCKED;
    // data port writes land on the selected index
    if (open_wr)
    begin
      if (idx_ff == `CPGB_IDX_LDN)
        nxt_ldn = req.wdata;
      else if (cpgb_hit(idx_ff, ldn_ff, `CPGB_IDX_EN, `CPGB_LDN_EN))
        nxt_en = req.wdata;
      else if (cpgb_hit(idx_ff, ldn_ff, `CPGB_IDX_DIR, `CPGB_LDN_GPIO))
        nxt_dir = req.wdata[W-1:0];
      else if (cpgb_hit(idx_ff, ldn_ff, `CPGB_IDX_DATA, `CPGB_LDN_GPIO))
        nxt_dout = (dout_ff & dir_ff) | (req.wdata[W-1:0] & ~dir_ff);
      else if (cpgb_hit(idx_ff, ldn_ff, `CPGB_IDX_INV, `CPGB_LDN_GPIO))
        nxt_inv = req.wdata[W-1:0];
    end
    // reads answer one cycle later
    if (req.rd && (req.idx_sel || req.dat_sel))
    begin
      nxt_rvalid = 1'b1;
      if (state_ff != CPGB_OPEN)
        nxt_rdata = `CPGB_LOCKED_RD;
      else if (req.idx_sel)
        nxt_rdata = idx_ff;
      else if (idx_ff == `CPGB_IDX_LDN)
        nxt_rdata = ldn_ff;
      else if (cpgb_hit(idx_ff, ldn_ff, `CPGB_IDX_EN, `CPGB_LDN_EN))
        nxt_rdata = en_ff;
      else if (cpgb_hit(idx_ff, ldn_ff, `CPGB_IDX_DIR, `CPGB_LDN_GPIO))
        nxt_rdata = dir_ff;
      else if (cpgb_hit(idx_ff, ldn_ff, `CPGB_IDX_DATA, `CPGB_LDN_GPIO))
        nxt_rdata = data_view;
      else if (cpgb_hit(idx_ff, ldn_ff, `CPGB_IDX_INV, `CPGB_LDN_GPIO))
        nxt_rdata = inv_ff;
      else
        nxt_rdata = `CPGB_UNMAPPED_RD;
    end
    nxt_out = dout_ff ^ inv_ff;
    nxt_oe  = ~dir_ff & {W{en_ff[`CPGB_EN_BIT]}};
  end

  always_ff @(posedge CORE_CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff  <= CPGB_LOCKED;
      idx_ff    <= `CPGB_RST_IDX;
      ldn_ff    <= `CPGB_RST_LDN;
      en_ff     <= `CPGB_RST_EN;
      dir_ff    <= `CPGB_RST_DIR;
      dout_ff   <= `CPGB_RST_DATA;
      inv_ff    <= `CPGB_RST_INV;
      rdata_ff  <= `CPGB_UNMAPPED_RD;
      rvalid_ff <= 1'b0;
      out_ff    <= '0;
      oe_ff     <= '0;
    end
    else if (ce)
    begin
      state_ff  <= nxt_state;
      idx_ff    <= nxt_idx;
      ldn_ff    <= nxt_ldn;
      en_ff     <= nxt_en;
      dir_ff    <= nxt_dir;
      dout_ff   <= nxt_dout;
      inv_ff    <= nxt_inv;
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
      out_ff    <= nxt_out;
      oe_ff     <= nxt_oe;
    end
  end

  assign IO_RDATA_O  = rdata_ff;
  assign IO_RVALID_O = rvalid_ff;
  assign GPIO_OUT_O  = out_ff;
  assign GPIO_OE_O   = oe_ff;

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!rst_n);

  a_unlock_twice: assert property (
    (ce && req.wr && req.idx_sel && req.wdata == `CPGB_UNLOCK_VAL &&
     state_ff == CPGB_LOCKED) ##1
    (ce && req.wr && req.idx_sel && req.wdata == `CPGB_UNLOCK_VAL)
    |=> state_ff == CPGB_OPEN)
    else $error("two unlock writes did not open configuration");

  a_lock_exit: assert property (
    (ce && req.wr && req.idx_sel && req.wdata == `CPGB_LOCK_VAL &&
     state_ff == CPGB_OPEN) |=> state_ff == CPGB_LOCKED)
    else $error("lock write did not leave configuration");

  a_locked_blocks: assert property (
    (ce && req.wr && req.dat_sel && state_ff != CPGB_OPEN)
    |=> $stable(dir_ff) && $stable(dout_ff) && $stable(inv_ff))
    else $error("data write changed registers while locked");

  a_ldn_route: assert property (
    (ce && open_wr && idx_ff == `CPGB_IDX_DIR &&
     ldn_ff == `CPGB_LDN_GPIO) |=> dir_ff == $past(req.wdata[W-1:0]))
    else $error("direction write not taken in gpio device");

  a_enable_gate: assert property (
    (ce && !en_ff[`CPGB_EN_BIT]) |=> GPIO_OE_O == '0)
    else $error("pin driven while gpio disabled");

  a_dir_drive: assert property (
    (ce && en_ff[`CPGB_EN_BIT]) |=> GPIO_OE_O == ~$past(dir_ff))
    else $error("output enable does not follow direction");

  a_input_ignore: assert property (
    (ce && open_wr && idx_ff == `CPGB_IDX_DATA && ldn_ff == `CPGB_LDN_GPIO)
    |=> (dout_ff & dir_ff) == $past(dout_ff & dir_ff))
    else $error("input line data bit took a write");

  a_pin_polarity: assert property (
    ce |=> GPIO_OUT_O == ($past(dout_ff) ^ $past(inv_ff)))
    else $error("pin value does not match data and polarity");

  a_read_data: assert property (
    (ce && req.rd && req.dat_sel && state_ff == CPGB_OPEN &&
     idx_ff == `CPGB_IDX_DATA && ldn_ff == `CPGB_LDN_GPIO)
    |=> IO_RVALID_O && IO_RDATA_O == $past(data_view))
    else $error("data read returned wrong value");
endmodule
`default_nettype wire

// >>> tb/cpgb_pin_model.sv
// external circuit on the gpio header
// assumes one bench-chosen level per line whenever the bank is not driving
`timescale 1ns/100ps
`default_nettype none
module cpgb_pin_model
  import cpgb_pkg::*;
(
  input  wire logic [7:0] oe_i,
  input  wire logic [7:0] out_i,
  input  wire logic [7:0] ext_i,
  output logic      [7:0] pin_o
);
  // lines the bank drives show its value, the rest the outside level
  assign pin_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule
`default_nettype wire

// >>> tb/cpgb_top_tb.sv
// self-checking bench for the configuration-port gpio bank
// assumes cpgb_pin_model stands on the gpio header
`timescale 1ns/100ps
`default_nettype none
`include "cpgb_defines.svh"
`define CPGB_CHK(g, e) begin checks++; if ((g) !== (e)) begin \
  fail_count++; $display("unexpected at %0t: got %h exp %h", \
  $time, g, e); end end
module cpgb_top_tb
  import cpgb_pkg::*;
;
  logic        clk;
  logic        rst_n;
  logic        ce;
  logic [15:0] addr;
  logic        wr;
  logic        rd;
  logic        rvalid;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic [7:0]  gout;
  logic [7:0]  goe;
  logic [7:0]  gin;
  logic [7:0]  ext;
  logic [7:0]  dir;
  logic [7:0]  dat;
  logic [7:0]  inv;
  logic [7:0]  v;
  int          seed;
  int          checks;
  int          fail_count;

  cpgb_top #(.W(8)) dut (
    .CORE_CLK_I (clk),
    .RESET_N_I  (rst_n),
    .CLK_EN_I   (ce),
    .IO_ADDR_I  (addr),
    .IO_WR_I    (wr),
    .IO_RD_I    (rd),
    .IO_WDATA_I (wdata),
    .IO_RDATA_O (rdata),
    .IO_RVALID_O(rvalid),
    .GPIO_IN_I  (gin),
    .GPIO_OUT_O (gout),
    .GPIO_OE_O  (goe)
  );

  cpgb_pin_model pm (
    .oe_i (goe),
    .out_i(gout),
    .ext_i(ext),
    .pin_o(gin)
  );

  initial clk = 1'b0;
  always #10 clk = ~clk;

  task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic io_rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CPGB_CHK(rvalid, 1'b1)
    d = rdata;
  endtask

  task automatic cfg_wr(input logic [7:0] i, input logic [7:0] d);
    io_wr(`CPGB_IDX_PORT, i);
    io_wr(`CPGB_DAT_PORT, d);
  endtask

  task automatic cfg_rd(input logic [7:0] i, output logic [7:0] d);
    io_wr(`CPGB_IDX_PORT, i);
    io_rd(`CPGB_DAT_PORT, d);
  endtask

  // data register read: stored bit on outputs, pin through polarity on inputs
  function automatic logic [7:0] exp_rd(input logic [7:0] di, da, iv, p);
    return (~di & da) | (di & (p ^ iv));
  endfunction

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end

  initial
  begin
    seed = 32'h46d5;
    checks = 0;
    fail_count = 0;
    rst_n = 1'b0;
    ce = 1'b1;
    addr = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 8'h00;
    ext = 8'h00;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    io_rd(`CPGB_DAT_PORT, v);
    `CPGB_CHK(v, `CPGB_LOCKED_RD)
    // a single unlock followed by any other index port write stays locked
    io_wr(`CPGB_IDX_PORT, `CPGB_UNLOCK_VAL);
    io_wr(`CPGB_IDX_PORT, `CPGB_IDX_LDN);
    io_rd(`CPGB_DAT_PORT, v);
    `CPGB_CHK(v, `CPGB_LOCKED_RD)
    // a data-port write after one unlock relocks
    io_wr(`CPGB_IDX_PORT, `CPGB_UNLOCK_VAL);
    io_wr(`CPGB_DAT_PORT, 8'h5a);
    io_wr(`CPGB_IDX_PORT, `CPGB_UNLOCK_VAL);
    io_rd(`CPGB_DAT_PORT, v);
    `CPGB_CHK(v, `CPGB_LOCKED_RD)
    io_wr(`CPGB_IDX_PORT, `CPGB_UNLOCK_VAL);
    io_wr(`CPGB_IDX_PORT, `CPGB_IDX_DIR);
    io_rd(`CPGB_IDX_PORT, v);
    `CPGB_CHK(v, `CPGB_IDX_DIR)
    // a strobe while the clock enable is low is not taken
    @(posedge clk);
    ce <= 1'b0;
    io_wr(`CPGB_IDX_PORT, `CPGB_LOCK_VAL);
    ce <= 1'b1;
    io_rd(`CPGB_IDX_PORT, v);
    `CPGB_CHK(v, `CPGB_IDX_DIR)
    cfg_wr(`CPGB_IDX_LDN, `CPGB_LDN_GPIO);
    cfg_wr(`CPGB_IDX_DIR, 8'h00);
    repeat (3) @(posedge clk);
    #1;
    `CPGB_CHK(goe, 8'h00)
    cfg_wr(`CPGB_IDX_LDN, `CPGB_LDN_EN);
    cfg_rd(`CPGB_IDX_DIR, v);
    `CPGB_CHK(v, `CPGB_UNMAPPED_RD)
    cfg_rd(`CPGB_IDX_EN, v);
    cfg_wr(`CPGB_IDX_EN, v | 8'h80);
    cfg_rd(`CPGB_IDX_EN, v);
    `CPGB_CHK(v, 8'h80)
    cfg_wr(`CPGB_IDX_LDN, `CPGB_LDN_GPIO);
    cfg_rd(`CPGB_IDX_LDN, v);
    `CPGB_CHK(v, `CPGB_LDN_GPIO)
    dat = 8'h00;
    for (int k = 0; k < 24; k++)
    begin
      dir = 8'($random(seed));
      inv = 8'($random(seed));
      v   = 8'($random(seed));
      if (k == 0) dir = 8'h00;
      if (k == 1) inv = 8'hff;
      if (k == 2) dir = 8'hff;
      @(posedge clk);
      ext <= 8'($random(seed));
      cfg_wr(`CPGB_IDX_DIR, dir);
      cfg_wr(`CPGB_IDX_INV, inv);
      cfg_wr(`CPGB_IDX_DATA, v);
      dat = (dat & dir) | (v & ~dir);
      repeat (6) @(posedge clk);
      #1;
      `CPGB_CHK(goe, ~dir)
      `CPGB_CHK(gout & ~dir, (dat ^ inv) & ~dir)
      cfg_rd(`CPGB_IDX_DATA, v);
      `CPGB_CHK(v, exp_rd(dir, dat, inv, ext))
      cfg_rd(`CPGB_IDX_DIR, v);
      `CPGB_CHK(v, dir)
      cfg_rd(`CPGB_IDX_INV, v);
      `CPGB_CHK(v, inv)
    end
    io_wr(`CPGB_IDX_PORT, `CPGB_LOCK_VAL);
    io_rd(`CPGB_DAT_PORT, v);
    `CPGB_CHK(v, `CPGB_LOCKED_RD)
    // reset in mid-run puts every register back to its reset value
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    `CPGB_CHK(goe, 8'h00)
    `CPGB_CHK(gout, 8'h00)
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // two unlock writes on back-to-back edges
    addr  <= `CPGB_IDX_PORT;
    wdata <= `CPGB_UNLOCK_VAL;
    wr    <= 1'b1;
    repeat (2) @(posedge clk);
    wr <= 1'b0;
    io_rd(`CPGB_IDX_PORT, v);
    `CPGB_CHK(v, `CPGB_RST_IDX)
    cfg_wr(`CPGB_IDX_LDN, `CPGB_LDN_GPIO);
    cfg_rd(`CPGB_IDX_DIR, v);
    `CPGB_CHK(v, `CPGB_RST_DIR)
    report_and_stop();
  end
endmodule
`default_nettype wire
